/* src/ibc_exec.sv */
`timescale 1ns/1ps
// execution unit for increment, conditional branch, long call and long jump instructions
// Summary of operation
// - decrement-branch: decrement, branch if nonzero, no flags
// - increment wraps FF to 00, no flags
// - port increment starts from output latch
// - four increment forms, one cycle each
// - pointer increment carries low to high, two cycles
// - bit-set jump: pc plus three, branch if set
// - bit-set-clear jump clears bit when branching
// - bit-set-clear reads output latch, not pin
// - carry-set jump: pc plus two, no flags
// - indirect jump loads accumulator plus pointer
// - bit-clear jump: branch if bit zero
// - carry-clear jump leaves carry unchanged
// - accumulator-nonzero jump: branch on any one
// - accumulator-zero jump: branch when all zero
// - long call pushes pc plus three, low first
// - long call loads target high then low
// - long jump loads sixteen-bit absolute target
`include "ibc_map.svh"
module ibc_exec
(
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        START,
	input  wire logic [7:0]  OPCODE,
	input  wire logic [7:0]  BYTE2,
	input  wire logic [7:0]  BYTE3,
	input  wire logic [7:0]  ACC,
	input  wire logic        CARRY,
	input  wire logic [7:0]  OPND_LATCH,
	input  wire logic        BIT_LATCH,
	output logic      [15:0] PC,
	output logic      [7:0]  SP,
	output logic      [15:0] DATA_POINTER_VAL,
	output logic             MEM_WE,
	output logic      [7:0]  MEM_ADDR,
	output logic      [7:0]  MEM_WDATA,
	output logic             BIT_CLR,
	output logic      [7:0]  BIT_ADDR,
	output logic             DONE
);
	// OPND_LATCH is the operand value the core supplies: for ports it is the
	// output data latch, never the pin levels, so a read-modify-write can not
	// copy an externally pulled-low pin back into the latch.
	// BIT_LATCH is likewise the latch copy of the addressed bit.

	//////////////////////////////////////////////////////////////////////////
	// state and registers
	ibc_pkg::ibc_state_e state_reg;
	ibc_pkg::ibc_state_e state_next;
	ibc_pkg::ibc_addr_t  pc_reg;
	ibc_pkg::ibc_addr_t  pc_next;
	ibc_pkg::ibc_byte_t  sp_reg;
	ibc_pkg::ibc_byte_t  sp_next;
	ibc_pkg::ibc_addr_t  dp_reg;
	ibc_pkg::ibc_addr_t  dp_next;
	logic                we_reg;
	logic                we_next;
	ibc_pkg::ibc_byte_t  waddr_reg;
	ibc_pkg::ibc_byte_t  waddr_next;
	ibc_pkg::ibc_byte_t  wdata_reg;
	ibc_pkg::ibc_byte_t  wdata_next;
	logic                bclr_reg;
	logic                bclr_next;
	ibc_pkg::ibc_byte_t  baddr_reg;
	ibc_pkg::ibc_byte_t  baddr_next;
	logic                done_reg;
	logic                done_next;
	ibc_pkg::ibc_addr_t  tgt_reg;
	ibc_pkg::ibc_addr_t  tgt_next;
	ibc_pkg::ibc_addr_t  ret_reg;
	ibc_pkg::ibc_addr_t  ret_next;
	ibc_pkg::ibc_byte_t  dec_val;
	ibc_pkg::ibc_byte_t  inc_val;

	// the branch adder sits in its own module so its sign extension stays in one
	// place; the carrier keeps the request and the result together
	ibc_tgt_if tif ();

	ibc_branch_calc u_calc
	(
		.t (tif.calc)
	);

	//////////////////////////////////////////////////////////////////////////
	// operand arithmetic, wrapping at byte width; the decrement-branch test
	// looks at the new value, so an old 01 falls through and 00 wraps to FF
	assign dec_val = OPND_LATCH - 8'h01;
	assign inc_val = OPND_LATCH + 8'h01;

	// branch adder request: base is the pc past the instruction
	always_comb
	begin
		tif.base = pc_reg + `IBC_LEN_TWO;
		tif.disp = BYTE2;
		tif.take = 1'b0;
		if (OPCODE == `IBC_OP_JBS || OPCODE == `IBC_OP_JBSC || OPCODE == `IBC_OP_JBN)
		begin
			tif.base = pc_reg + `IBC_LEN_THREE;
			tif.disp = BYTE3;
		end
		else if (OPCODE == `IBC_OP_DECREMENT_BRANCH_NONZERO_DIR)
		begin
			tif.base = pc_reg + `IBC_LEN_THREE;
			tif.disp = BYTE3;
		end
		case (OPCODE)
			`IBC_OP_JBS:      tif.take = BIT_LATCH;
			`IBC_OP_JBSC:     tif.take = BIT_LATCH;
			`IBC_OP_JBN:      tif.take = ~BIT_LATCH;
			`IBC_OP_JCS:      tif.take = CARRY;
			`IBC_OP_JCN:      tif.take = ~CARRY;
			`IBC_OP_JANZ:     tif.take = (ACC != 8'h00);
			`IBC_OP_JAZ:      tif.take = (ACC == 8'h00);
			`IBC_OP_DECREMENT_BRANCH_NONZERO_DIR: tif.take = (dec_val != 8'h00);
			default:
			begin
				if (OPCODE[7:3] == `IBC_OP_DECREMENT_BRANCH_NONZERO_REG)
					tif.take = (dec_val != 8'h00);
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// decode and sequence; two-cycle forms commit the pc in the second cycle
	always_comb
	begin
		state_next = state_reg;
		pc_next    = pc_reg;
		sp_next    = sp_reg;
		dp_next    = dp_reg;
		we_next    = 1'b0;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		bclr_next  = 1'b0;
		baddr_next = baddr_reg;
		done_next  = 1'b0;
		tgt_next   = tgt_reg;
		ret_next   = ret_reg;
		case (state_reg)
			ibc_pkg::IBC_ST_IDLE:
			begin
				if (START)
				begin
					state_next = ibc_pkg::IBC_ST_EXEC2;
					// capture the target now: the second cycle then needs no
					// adder and no operand input
					tgt_next   = tif.result;
					if (OPCODE == `IBC_OP_INC_A)
					begin
						// accumulator result goes out on the write port at 0xE0 handled
						// by the core; here the strobe, the address and the value are all produced
						we_next    = 1'b1;
						waddr_next = `IBC_ACC_ADDR;
						wdata_next = ACC + 8'h01;
						pc_next    = pc_reg + `IBC_LEN_ONE;
						state_next = ibc_pkg::IBC_ST_IDLE;
						done_next  = 1'b1;
					end
					else if (OPCODE[7:3] == `IBC_OP_INC_REG)
					begin
						we_next    = 1'b1;
						waddr_next = {5'h00, OPCODE[2:0]};
						wdata_next = inc_val;
						pc_next    = pc_reg + `IBC_LEN_ONE;
						state_next = ibc_pkg::IBC_ST_IDLE;
						done_next  = 1'b1;
					end
					else if (OPCODE == `IBC_OP_INC_DIR)
					begin
						we_next    = 1'b1;
						waddr_next = BYTE2;
						wdata_next = inc_val;
						pc_next    = pc_reg + `IBC_LEN_TWO;
						state_next = ibc_pkg::IBC_ST_IDLE;
						done_next  = 1'b1;
					end
					else if (OPCODE[7:1] == `IBC_OP_INC_IND)
					begin
						// BYTE2 carries the indirect address read from the pointer register
						we_next    = 1'b1;
						waddr_next = BYTE2;
						wdata_next = inc_val;
						pc_next    = pc_reg + `IBC_LEN_ONE;
						state_next = ibc_pkg::IBC_ST_IDLE;
						done_next  = 1'b1;
					end
					else if (OPCODE[7:3] == `IBC_OP_DECREMENT_BRANCH_NONZERO_REG)
					begin
						we_next    = 1'b1;
						waddr_next = {5'h00, OPCODE[2:0]};
						wdata_next = dec_val;
					end
					else if (OPCODE == `IBC_OP_DECREMENT_BRANCH_NONZERO_DIR)
					begin
						we_next    = 1'b1;
						waddr_next = BYTE2;
						wdata_next = dec_val;
					end
					else if (OPCODE == `IBC_OP_INC_DATA_POINTER)
						tgt_next = pc_reg + `IBC_LEN_ONE;
					else if (OPCODE == `IBC_OP_JBSC)
					begin
						bclr_next  = BIT_LATCH;
						baddr_next = BYTE2;
					end
					else if (OPCODE == `IBC_OP_JIND)
						tgt_next = dp_reg + {8'h00, ACC};
					else if (OPCODE == `IBC_OP_LONG_SUBROUTINE_CALL)
					begin
						// low return byte first, at the pre-incremented stack
						// pointer; the high byte follows in the next cycle
						ret_next   = pc_reg + `IBC_LEN_THREE;
						sp_next    = sp_reg + 8'h01;
						we_next    = 1'b1;
						waddr_next = sp_reg + 8'h01;
						wdata_next = ret_next[7:0];
						tgt_next   = {BYTE2, BYTE3};
					end
					else if (OPCODE == `IBC_OP_LONG_JUMP_OP)
						tgt_next = {BYTE2, BYTE3};
					else if (!(OPCODE == `IBC_OP_JBS || OPCODE == `IBC_OP_JBN ||
						OPCODE == `IBC_OP_JCS || OPCODE == `IBC_OP_JCN ||
						OPCODE == `IBC_OP_JAZ || OPCODE == `IBC_OP_JANZ))
					begin
						// not ours: finish at once, leave pc for the owning unit
						state_next = ibc_pkg::IBC_ST_IDLE;
						done_next  = 1'b1;
					end
				end
			end
			// second cycle: every two-cycle form commits its pc here, while the
			// long call goes on to push the high byte of its return address
			ibc_pkg::IBC_ST_EXEC2:
			begin
				if (OPCODE != `IBC_OP_LONG_SUBROUTINE_CALL)
				begin
					pc_next    = tgt_reg;
					done_next  = 1'b1;
					state_next = ibc_pkg::IBC_ST_IDLE;
					// one 16-bit add, so a low-byte carry reaches the high byte at once
					if (OPCODE == `IBC_OP_INC_DATA_POINTER)
						dp_next = dp_reg + 16'h0001;
				end
				else
				begin
					sp_next    = sp_reg + 8'h01;
					we_next    = 1'b1;
					waddr_next = sp_reg + 8'h01;
					wdata_next = ret_reg[15:8];
					state_next = ibc_pkg::IBC_ST_PUSH_HI;
				end
			end
			// both return bytes are on the stack, so the jump to the target
			// can be committed without leaving a half-built frame
			ibc_pkg::IBC_ST_PUSH_HI:
			begin
				pc_next    = tgt_reg;
				done_next  = 1'b1;
				state_next = ibc_pkg::IBC_ST_IDLE;
			end
			// unused state encoding: fall back to idle
			default:
				state_next = ibc_pkg::IBC_ST_IDLE;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// sequencing state; target and return address are held here, so the
	// core may change the operand inputs once done has been seen
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg <= ibc_pkg::IBC_ST_IDLE;
			tgt_reg   <= `IBC_PC_RESET;
			ret_reg   <= `IBC_PC_RESET;
			done_reg  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			tgt_reg   <= tgt_next;
			ret_reg   <= ret_next;
			done_reg  <= done_next;
		end
	end

	// architectural pointers; flags are never touched by this unit
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			pc_reg <= `IBC_PC_RESET;
			sp_reg <= `IBC_SP_RESET;
			dp_reg <= `IBC_DP_RESET;
		end
		else
		begin
			pc_reg <= pc_next;
			sp_reg <= sp_next;
			dp_reg <= dp_next;
		end
	end

	// memory write and bit-clear side effects, one-cycle pulses
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			we_reg    <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			bclr_reg  <= 1'b0;
			baddr_reg <= 8'h00;
		end
		else
		begin
			we_reg    <= we_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			bclr_reg  <= bclr_next;
			baddr_reg <= baddr_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign PC        = pc_reg;
	assign SP        = sp_reg;
	assign DATA_POINTER_VAL  = dp_reg;
	assign MEM_WE    = we_reg;
	assign MEM_ADDR  = waddr_reg;
	assign MEM_WDATA = wdata_reg;
	assign BIT_CLR   = bclr_reg;
	assign BIT_ADDR  = baddr_reg;
	assign DONE      = done_reg;
endmodule

/* src/ibc_map.svh */
// constants for the increment, branch and call execution block
`ifndef IBC_MAP_SVH
`define IBC_MAP_SVH
`define IBC_OP_INC_A     8'h04
`define IBC_OP_INC_DIR   8'h05
`define IBC_OP_INC_IND   7'h03
`define IBC_OP_INC_REG   5'h01
`define IBC_OP_DECREMENT_BRANCH_NONZERO_REG  5'h1B
`define IBC_OP_DECREMENT_BRANCH_NONZERO_DIR  8'hD5
`define IBC_OP_INC_DATA_POINTER  8'hA3
`define IBC_OP_JBS       8'h20
`define IBC_OP_JBSC      8'h10
`define IBC_OP_JBN       8'h30
`define IBC_OP_JCS       8'h40
`define IBC_OP_JCN       8'h50
`define IBC_OP_JAZ       8'h60
`define IBC_OP_JANZ      8'h70
`define IBC_OP_JIND      8'h73
`define IBC_OP_LONG_SUBROUTINE_CALL     8'h12
`define IBC_OP_LONG_JUMP_OP      8'h02
`define IBC_LEN_ONE      16'h0001
`define IBC_LEN_TWO      16'h0002
`define IBC_LEN_THREE    16'h0003
`define IBC_PC_RESET     16'h0000
`define IBC_SP_RESET     8'h07
`define IBC_DP_RESET     16'h0000
`define IBC_ACC_ADDR     8'hE0
`endif

/* src/ibc_pkg.sv */
// types shared by the execution block and its helpers
package ibc_pkg;
	typedef enum logic [1:0] {
		IBC_ST_IDLE,
		IBC_ST_EXEC2,
		IBC_ST_PUSH_HI
	} ibc_state_e;

	typedef logic [15:0] ibc_addr_t;
	typedef logic [7:0]  ibc_byte_t;
endpackage

/* src/ibc_tgt_if.sv */
`timescale 1ns/1ps
// target pc computation request and result between the sequencer and the adder
interface ibc_tgt_if;
	ibc_pkg::ibc_addr_t base;
	ibc_pkg::ibc_byte_t disp;
	logic               take;
	ibc_pkg::ibc_addr_t result;

	modport seq (output base, output disp, output take, input result);
	modport calc (input base, input disp, input take, output result);
endinterface

/* src/ibc_branch_calc.sv */
`timescale 1ns/1ps
// relative branch target adder
module ibc_branch_calc
(
	ibc_tgt_if.calc t
);
	ibc_pkg::ibc_addr_t sext;

	// sign-extend then add, modulo 64K; untaken keeps the advanced pc
	always_comb
	begin
		sext = {{8{t.disp[7]}}, t.disp};
		t.result = t.take ? ibc_pkg::ibc_addr_t'(t.base + sext) : t.base;
	end
endmodule

/* sim/ibc_exec_asserts.sv */
// concurrent checks on the execution block ports
`timescale 1ns/1ps
module ibc_exec_asserts
(
	input wire logic        MCLK,
	input wire logic        RST,
	input wire logic        START,
	input wire logic [7:0]  OPCODE,
	input wire logic [7:0]  BYTE2,
	input wire logic [7:0]  BYTE3,
	input wire logic [7:0]  ACC,
	input wire logic        CARRY,
	input wire logic [7:0]  OPND_LATCH,
	input wire logic        BIT_LATCH,
	input wire logic [15:0] PC,
	input wire logic [7:0]  SP,
	input wire logic [15:0] DATA_POINTER_VAL,
	input wire logic        MEM_WE,
	input wire logic [7:0]  MEM_ADDR,
	input wire logic [7:0]  MEM_WDATA,
	input wire logic        BIT_CLR,
	input wire logic [7:0]  BIT_ADDR,
	input wire logic        DONE
);
	default clocking dc @(posedge MCLK); endclocking
	default disable iff (RST);
	////////////////////////////////////////////////////////////////////////////
	inc_direct_a: assert property (START && OPCODE == 8'h05 |=> MEM_WE && DONE
		&& MEM_WDATA == $past(OPND_LATCH) + 8'h01 && MEM_ADDR == $past(BYTE2))
		else $error("direct increment write wrong");
	ptr_inc_a: assert property (START && OPCODE == 8'hA3 |=> !DONE ##1 DONE
		&& DATA_POINTER_VAL == $past(DATA_POINTER_VAL, 2) + 16'h0001)
		else $error("pointer increment wrong");
	// the push order is the hazard here: high byte first corrupts every return
	call_push_a: assert property (START && OPCODE == 8'h12 |=> MEM_WE
		&& MEM_ADDR == $past(SP) + 8'h01 && MEM_WDATA == 8'($past(PC) + 16'h0003)
		##1 MEM_WE && MEM_ADDR == $past(SP, 2) + 8'h02
		&& MEM_WDATA == 8'(($past(PC, 2) + 16'h0003) >> 8)
		##1 DONE && SP == $past(SP, 3) + 8'h02 && PC == {$past(BYTE2, 3), $past(BYTE3, 3)})
		else $error("long call sequence wrong");
	long_jump_a: assert property (START && OPCODE == 8'h02 |=> ##1 DONE
		&& PC == {$past(BYTE2, 2), $past(BYTE3, 2)})
		else $error("long jump target wrong");
	ind_jump_a: assert property (START && OPCODE == 8'h73 |=> ##1 DONE
		&& PC == $past(DATA_POINTER_VAL, 2) + {8'h00, $past(ACC, 2)})
		else $error("indirect jump target wrong");
	bit_clear_a: assert property (START && OPCODE == 8'h10 && BIT_LATCH |=> BIT_CLR
		&& BIT_ADDR == $past(BYTE2))
		else $error("bit not cleared");
	bit_keep_a: assert property (START && (OPCODE inside {8'h20, 8'h30}
		|| OPCODE == 8'h10 && !BIT_LATCH) |=> !BIT_CLR [*2])
		else $error("bit cleared wrongly");
	carry_skip_a: assert property (START && OPCODE == 8'h50 && CARRY |=> ##1 DONE
		&& PC == $past(PC, 2) + 16'h0002)
		else $error("carry clear jump wrong");
	acc_zero_a: assert property (START && OPCODE == 8'h60 && ACC == 8'h00 |=> ##1
		PC == $past(PC, 2) + 16'h0002 + {{8{$past(BYTE2[7], 2)}}, $past(BYTE2, 2)})
		else $error("zero jump target wrong");
endmodule

bind ibc_exec ibc_exec_asserts u_ibc_exec_asserts (.MCLK, .RST, .START, .OPCODE, .BYTE2,
	.BYTE3, .ACC, .CARRY, .OPND_LATCH, .BIT_LATCH, .PC, .SP, .DATA_POINTER_VAL, .MEM_WE,
	.MEM_ADDR, .MEM_WDATA, .BIT_CLR, .BIT_ADDR, .DONE);

/* sim/tb.sv */
// self-checking bench for the execution block
`timescale 1ns/1ps
module tb;
	typedef struct {logic [15:0] pc; logic [7:0] sp; logic [15:0] dp;} ibc_note_s;
	logic        MCLK = 1'b0;
	logic        RST = 1'b1;
	logic        START = 1'b0;
	logic        CARRY = 1'b0;
	logic        BIT_LATCH = 1'b0;
	logic [7:0]  OPCODE = 8'h00, BYTE2 = 8'h00, BYTE3 = 8'h00, ACC = 8'h00, OPND_LATCH = 8'h00;
	logic [15:0] PC, DATA_POINTER_VAL, w, pc_m = 16'h0000, dp_m = 16'h0000;
	logic [7:0]  SP, MEM_ADDR, MEM_WDATA, BIT_ADDR, a, o, sp_m = 8'h07;
	logic        MEM_WE, BIT_CLR, DONE;
	ibc_note_s   nq[$], cur;
	logic [15:0] wq[$];
	logic [7:0]  bq[$];
	logic [7:0]  rop [14] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h73, 8'h12,
		8'h02, 8'hD5, 8'hD8, 8'hDF, 8'hFF};
	int          fail_count = 0, cmp_count = 0, seed = 84530;

	initial forever #5 MCLK = ~MCLK;

	ibc_exec u_ibc_exec (.MCLK, .RST, .START, .OPCODE, .BYTE2, .BYTE3, .ACC, .CARRY,
		.OPND_LATCH, .BIT_LATCH, .PC, .SP, .DATA_POINTER_VAL, .MEM_WE, .MEM_ADDR, .MEM_WDATA,
		.BIT_CLR, .BIT_ADDR, .DONE);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] r8();
		return 8'($random(seed));
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic conclude();
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// notes the expected outcome first, then presents the instruction until done
	task automatic step(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
		input logic c, input logic bt);
		logic [15:0] nx;
		logic [7:0]  d;
		logic [7:0]  wa;
		logic [7:0]  wr;
		logic        tk;
		logic        dj;
		int          n;
		ibc_note_s   e;
		// length: one byte for short increments, three for bit jumps and call
		nx = pc_m + ((op inside {8'h10, 8'h20, 8'h30, 8'h12, 8'hD5}) ? 16'h0003 :
			(op == 8'h05 || !(op inside {[8'h04:8'h0F], 8'hA3})) ? 16'h0002 : 16'h0001);
		d = (op inside {8'h10, 8'h20, 8'h30, 8'hD5}) ? b3 : b2;
		dj = (op == 8'hD5 || op[7:3] == 5'h1B);
		tk = 1'b0;
		case (op)
			8'h10, 8'h20:
			begin
				tk = bt;
				if (op == 8'h10 && bt)
					bq.push_back(b2);
			end
			8'h30: tk = !bt;
			8'h40: tk = c;
			8'h50: tk = !c;
			8'h60: tk = (a == 8'h00);
			8'h70: tk = (a != 8'h00);
			8'h02: nx = {b2, b3};
			8'h73: nx = dp_m + {8'h00, a};
			8'hFF: nx = pc_m;
			8'h12:
			begin
				wq.push_back({sp_m + 8'h01, nx[7:0]});
				wq.push_back({sp_m + 8'h02, nx[15:8]});
				sp_m = sp_m + 8'h02;
				nx = {b2, b3};
			end
			8'hA3: dp_m = dp_m + 16'h0001;
			default:
			begin
				// accumulator increments land at E0, register forms at the bank slot
				tk = dj && (o != 8'h01);
				wr = dj ? o - 8'h01 : o + 8'h01;
				if (op == 8'h04)
					wr = a + 8'h01;
				wa = b2;
				if (op == 8'h04)
					wa = 8'hE0;
				else if (op[7:3] == 5'h01 || op[7:3] == 5'h1B)
					wa = {5'h00, op[2:0]};
				wq.push_back({wa, wr});
			end
		endcase
		if (tk)
			nx = nx + {{8{d[7]}}, d};
		pc_m = nx;
		e.pc = nx;
		e.sp = sp_m;
		e.dp = dp_m;
		nq.push_back(e);
		@(posedge MCLK);
		OPCODE <= op;
		BYTE2 <= b2;
		BYTE3 <= b3;
		ACC <= a;
		CARRY <= c;
		BIT_LATCH <= bt;
		OPND_LATCH <= o;
		START <= 1'b1;
		@(posedge MCLK);
		START <= 1'b0;
		n = 0;
		do
		begin
			@(negedge MCLK);
			n++;
		end while (DONE !== 1'b1 && n < 8);
		if (DONE !== 1'b1)
		begin
			fail_count++;
			conclude();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watcher: completions retire notes, memory writes retire expected bytes
	always @(negedge MCLK)
	begin
		if (DONE === 1'b1)
		begin
			cur = nq.pop_front();
			chk("PC", cur.pc, PC);
			chk("SP", {8'h00, cur.sp}, {8'h00, SP});
			chk("DATA_POINTER", cur.dp, DATA_POINTER_VAL);
		end
		if (MEM_WE === 1'b1)
		begin
			w = (wq.size() > 0) ? wq.pop_front() : 16'hXXXX;
			chk("MEM_ADDR_WDATA", w, {MEM_ADDR, MEM_WDATA});
		end
		if (BIT_CLR === 1'b1)
		begin
			w = (bq.size() > 0) ? {8'h00, bq.pop_front()} : 16'hXXXX;
			chk("BIT_ADDR", w, {8'h00, BIT_ADDR});
		end
	end

	initial
	begin
		// accumulator starts at FF so the first increment wraps to 00
		a = 8'hFF;
		o = 8'hFF;
		repeat (8) @(posedge MCLK);
		RST <= 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			step(8'(8'h04 + i), r8(), 8'h00, 1'b0, 1'b0);
			o = r8();
		end
		// long run so the low pointer byte carries into the high byte
		repeat (256) step(8'hA3, 8'h00, 8'h00, 1'b0, 1'b0);
		step(8'h02, r8(), r8(), 1'b0, 1'b0);
		repeat (300)
		begin
			a = (r8() < 8'h40) ? 8'h00 : r8();
			o = (r8() < 8'h30) ? 8'h01 : r8();
			step(rop[r8() % 14], r8(), r8(), r8() > 8'h7F, r8() > 8'h7F);
		end
		@(posedge MCLK);
		RST <= 1'b1;
		repeat (2) @(posedge MCLK);
		RST <= 1'b0;
		pc_m = 16'h0000;
		dp_m = 16'h0000;
		sp_m = 8'h07;
		@(negedge MCLK);
		chk("PC", 16'h0000, PC);
		chk("SP", 16'h0007, {8'h00, SP});
		chk("DATA_POINTER", 16'h0000, DATA_POINTER_VAL);
		step(8'h12, 8'h12, 8'h34, 1'b0, 1'b0);
		// let the watcher retire the last completion before the verdict
		@(posedge MCLK);
		chk("LEFT_OVER", 16'h0000, 16'(nq.size() + wq.size() + bq.size()));
		conclude();
	end
endmodule
